// ---- pkg/rx_support_regs.svh ----
/*
 Register offsets, field positions, reset values and timing counts for the
 receiver support block. Assumes a 32-bit classic Wishbone slave, byte addressed.
*/
`ifndef RX_SUPPORT_REGS_SVH
`define RX_SUPPORT_REGS_SVH

// Register byte offsets
`define REG_CTRL     8'h00
`define REG_CFG      8'h04
`define REG_CARRIER  8'h08
`define REG_BW       8'h0C
`define REG_TIMEOUT  8'h10
`define REG_SIGNAL   8'h14
`define REG_STATUS   8'h18
`define REG_RESULT   8'h1C

// Control register bits (write one to launch or clear)
`define CTRL_CAL_LAUNCH   0
`define CTRL_MEASURE      1
`define CTRL_CLEAR_FLAGS  2

// Configuration register fields
`define CFG_AUTO_CORR     0
`define CFG_CLEAR_CORR    1
`define CFG_PRE_DET_EN    2
`define CFG_PRE_GATE      3
`define CFG_TEMP_OFF      4
`define CFG_CAL_ON_TEMP   5
`define CFG_LEN_LO        6
`define CFG_LEN_HI        7
`define CFG_TEMP_SEL_LO   8
`define CFG_TEMP_SEL_HI   9
`define CFG_TRIG_LO       10
`define CFG_TRIG_HI       12
`define CFG_TOL_LO        16
`define CFG_TOL_HI        20
`define CFG_RESET         32'h0000_0000

// Status bits
`define ST_PREAMBLE       0
`define ST_TEMP           1
`define ST_TIMEOUT        2
`define ST_CAL_BUSY       3
`define ST_CORR_PHASE     4
`define ST_SIGNAL         5

// Trigger select codes
`define TRIG_NONE         3'h0
`define TRIG_SIGNAL       3'h1
`define TRIG_PREAMBLE     3'h6
`define TRIG_BOTH         3'h7

// Timing
`define CLK_MHZ           250
`define CAL_TIME_MS       10
`define CAL_CYCLES        ((`CAL_TIME_MS) * 1000 * (`CLK_MHZ))
`define MEAS_BITS         3'h4
`define TIMEOUT_BITS      16

`endif

// ---- pkg/rx_support_pkg.sv ----
/*
 Types for the receiver support block.
 Assumes the register header is included by the design file.
*/
package rx_support_pkg;

   // Wishbone request bundle
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } wb_req_t;

   // Correction sequencer states
   typedef enum logic [3:0] {
      CORR_IDLE = 4'b0001,
      CORR_WAIT = 4'b0010,
      CORR_MEAS = 4'b0100,
      CORR_DONE = 4'b1000
   } corr_state_t;

endpackage

// ---- src/rx_support.sv ----
/*
 Receiver support logic: frequency error measure and correction, preamble
 detector, IQ calibration control and receive timeouts, with a Wishbone slave.
 Assumes rx data, bit tick, error estimate, sync, temperature and mode inputs
 arrive from outside the clock domain and are synchronised here.
*/
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rx_support_regs.svh"

module rx_support
   import rx_support_pkg::*;
#(
   parameter int CAL_CYCLES = `CAL_CYCLES,
   parameter int FREQ_W = 24,
   parameter int ERR_W = 16
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rx_enable,
   input wire logic standby_mode,
   input wire logic manual_reset,
   input wire logic bit_tick,
   input wire logic rx_bit,
   input wire logic sync_match_flag,
   input wire logic [7:0] signal_level_reading,
   input wire logic [ERR_W-1:0] freq_error_sample,
   input wire logic [7:0] temp_reading,
   output logic [FREQ_W-1:0] carrier_freq,
   output logic [7:0] active_bandwidth,
   output logic preamble_found_flag,
   output logic timeout_irq,
   output logic cal_busy
);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers (two flops; first flop read only by the second)
   logic [1:0] s_rxen_q, s_sby_q, s_mrst_q, s_tick_q, s_bit_q, s_sync_q;
   logic [7:0] s_sig1_q, s_sig2_q, s_tmp1_q, s_tmp2_q;
   logic [ERR_W-1:0] s_err1_q, s_err2_q;
   always_ff @(posedge sys_clk) begin
      s_rxen_q <= {s_rxen_q[0], rx_enable};
      s_sby_q <= {s_sby_q[0], standby_mode};
      s_mrst_q <= {s_mrst_q[0], manual_reset};
      s_tick_q <= {s_tick_q[0], bit_tick};
      s_bit_q <= {s_bit_q[0], rx_bit};
      s_sync_q <= {s_sync_q[0], sync_match_flag};
      s_sig1_q <= signal_level_reading;
      s_sig2_q <= s_sig1_q;
      s_tmp1_q <= temp_reading;
      s_tmp2_q <= s_tmp1_q;
      s_err1_q <= freq_error_sample;
      s_err2_q <= s_err1_q;
   end
   wire logic rx_on = s_rxen_q[1];
   wire logic sby = s_sby_q[1];
   wire logic mrst = s_mrst_q[1];
   wire logic tick = s_tick_q[1];
   wire logic dbit = s_bit_q[1];
   wire logic sync_in = s_sync_q[1];

   ////////////////////////////////////////////////////////////////////////////
   // Registers, edge history and status state
   wb_req_t req;
   assign req = '{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i};
   logic [31:0] cfg_q, cfg_d, rdat_q, rdat_d;
   logic ack_q, ack_d;
   logic [FREQ_W-1:0] base_q, base_d, freq_q, freq_d;
   logic [15:0] bw_q, bw_d;
   logic [7:0] abw_q, abw_d;
   logic [23:0] tmo_q, tmo_d;
   logic [7:0] sig_lim_q, sig_lim_d;
   logic rx_q, tick_q, mrst_q, tick_prev_q;
   logic pre_q, pre_d, temp_q, temp_d, tout_q, tout_d, sigf_q, sigf_d;
   logic [ERR_W-1:0] err_q, err_d;
   logic [ERR_W+1:0] acc_q, acc_d;
   logic [7:0] tref_q, tref_d;
   logic pcal_q, pcal_d;
   logic [31:0] cal_cnt_q, cal_cnt_d;
   logic cal_q, cal_d;
   corr_state_t cst_q, cst_d;
   logic [2:0] mcnt_q, mcnt_d;
   logic corr_phase_q, corr_phase_d;
   logic [4:0] run_q, run_d;
   logic [5:0] pcnt_q, pcnt_d;
   logic prev_bit_q, prev_bit_d;
   logic [23:0] tcnt_q [3];
   logic [23:0] tcnt_d [3];
   logic [2:0] tdone_q, tdone_d;

   wire logic rx_rise = rx_on & ~rx_q;
   wire logic tick_rise = tick & ~tick_prev_q;
   wire logic wr = req.cyc & req.stb & req.we & ~ack_q;
   wire logic rd = req.cyc & req.stb & ~req.we & ~ack_q;
   wire logic wr_ctrl = wr & (req.adr == `REG_CTRL) & req.sel[0];
   wire logic [1:0] plen = cfg_q[`CFG_LEN_HI:`CFG_LEN_LO];
   wire logic [2:0] trig = cfg_q[`CFG_TRIG_HI:`CFG_TRIG_LO];
   wire logic [4:0] tol = cfg_q[`CFG_TOL_HI:`CFG_TOL_LO];

   // Preamble length in bits from length code; reserved code uses two bytes
   logic [5:0] need_bits;
   always_comb begin
      unique case (plen)
         2'h0: need_bits = 6'h08;
         2'h1: need_bits = 6'h10;
         2'h2: need_bits = 6'h18;
         default: need_bits = 6'h10;
      endcase
   end

   // Temperature threshold 5/10/15/20 degrees
   wire logic [7:0] tstep = 8'(({6'h00, cfg_q[`CFG_TEMP_SEL_HI:`CFG_TEMP_SEL_LO]} + 8'h01) * 8'h05);
   wire logic [7:0] tdiff = (s_tmp2_q > tref_q) ? 8'(s_tmp2_q - tref_q) : 8'(tref_q - s_tmp2_q);
   wire logic temp_evt = ~cfg_q[`CFG_TEMP_OFF] & (tdiff >= tstep);

   // Timeout enables per trigger code: signal, preamble, sync
   logic [2:0] ten;
   always_comb begin
      unique case (trig)
         `TRIG_SIGNAL: ten = 3'b101;
         `TRIG_PREAMBLE: ten = 3'b010;
         `TRIG_BOTH: ten = 3'b011;
         default: ten = 3'b000;
      endcase
   end

   wire logic sig_hit = s_sig2_q > sig_lim_q;
   wire logic [2:0] evt = {sync_in, pre_q, sigf_q};
   logic pre_evt;

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      cfg_d = cfg_q;
      base_d = base_q;
      freq_d = freq_q;
      bw_d = bw_q;
      tmo_d = tmo_q;
      sig_lim_d = sig_lim_q;
      rdat_d = rdat_q;
      ack_d = 1'b0;
      pre_d = pre_q;
      temp_d = temp_q;
      tout_d = tout_q;
      sigf_d = sigf_q | sig_hit;
      err_d = err_q;
      acc_d = acc_q;
      tref_d = tref_q;
      pcal_d = 1'b0;
      cal_cnt_d = cal_cnt_q;
      cal_d = cal_q;
      cst_d = cst_q;
      mcnt_d = mcnt_q;
      corr_phase_d = corr_phase_q;
      run_d = run_q;
      pcnt_d = pcnt_q;
      prev_bit_d = prev_bit_q;
      tcnt_d = tcnt_q;
      tdone_d = tdone_q;
      pre_evt = 1'b0;

      // Preamble detector: count alternating bits, tolerate up to tol misses
      if (tick_rise && cfg_q[`CFG_PRE_DET_EN]) begin
         prev_bit_d = dbit;
         if (dbit != prev_bit_q) begin
            if (pcnt_q + 6'h01 >= need_bits) begin
               pre_evt = 1'b1;
               pcnt_d = 6'h00;
            end else begin
               pcnt_d = pcnt_q + 6'h01;
            end
         end else if (run_q < tol) begin
            run_d = run_q + 5'h01;
         end else begin
            pcnt_d = 6'h00;
            run_d = 5'h00;
         end
      end
      if (pre_evt) begin
         pre_d = 1'b1;
         run_d = 5'h00;
      end

      // Correction and measurement sequencer
      unique case (cst_q)
         CORR_IDLE: begin
            if (rx_rise && cfg_q[`CFG_AUTO_CORR]) begin
               if (cfg_q[`CFG_CLEAR_CORR]) freq_d = base_q;
               corr_phase_d = 1'b1;
               cst_d = cfg_q[`CFG_PRE_GATE] ? CORR_WAIT : CORR_MEAS;
            end else if ((wr_ctrl && req.dat[`CTRL_MEASURE])
                         || (pre_evt && cfg_q[`CFG_PRE_GATE])) begin
               cst_d = CORR_MEAS;
            end
            mcnt_d = 3'h0;
            acc_d = '0;
         end
         CORR_WAIT: if (pre_evt) cst_d = CORR_MEAS;
         CORR_MEAS: begin
            if (tick_rise) begin
               acc_d = acc_q + {{2{s_err2_q[ERR_W-1]}}, s_err2_q};
               mcnt_d = mcnt_q + 3'h1;
               if (mcnt_q + 3'h1 == `MEAS_BITS) cst_d = CORR_DONE;
            end
         end
         CORR_DONE: begin
            err_d = acc_q[ERR_W+1:2];
            if (corr_phase_q) begin
               freq_d = freq_q - FREQ_W'($signed(acc_q[ERR_W+1:2]));
            end
            corr_phase_d = 1'b0;
            cst_d = CORR_IDLE;
         end
         default: cst_d = CORR_IDLE;
      endcase
      if (!rx_on && cst_q != CORR_IDLE && cst_q != CORR_DONE) begin
         cst_d = CORR_IDLE;
         corr_phase_d = 1'b0;
      end

      // Temperature watch and calibration
      if (temp_evt) begin
         temp_d = 1'b1;
         tref_d = s_tmp2_q;
      end
      if ((temp_evt && cfg_q[`CFG_CAL_ON_TEMP])
          || (mrst && !mrst_q)
          || (wr_ctrl && req.dat[`CTRL_CAL_LAUNCH] && sby)) begin
         cal_d = 1'b1;
         cal_cnt_d = 32'(CAL_CYCLES);
      end else if (cal_q) begin
         cal_cnt_d = cal_cnt_q - 32'h1;
         if (cal_cnt_q <= 32'h1) cal_d = 1'b0;
      end

      // Timeout counters per pairing, counted in bit periods
      for (int i = 0; i < 3; i++) begin
         if (rx_rise) begin
            tcnt_d[i] = '0;
            tdone_d[i] = 1'b0;
         end else if (rx_on && !tdone_q[i] && ten[i]) begin
            if (evt[i]) begin
               tdone_d[i] = 1'b1;
            end else if (tick_rise) begin
               tcnt_d[i] = tcnt_q[i] + 24'h1;
               if (tcnt_q[i] + 24'h1 == 24'(tmo_q[8*i +: 8]) * 24'(`TIMEOUT_BITS)
                   && tmo_q[8*i +: 8] != 8'h00) begin
                  tout_d = 1'b1;
                  tdone_d[i] = 1'b1;
               end
            end
         end
      end
      if (rx_rise) sigf_d = sig_hit;

      // Wishbone slave, one wait state, ack one cycle
      if (wr) begin
         ack_d = 1'b1;
         unique case (req.adr)
            `REG_CFG: cfg_d = req.dat;
            `REG_CARRIER: begin
               base_d = req.dat[FREQ_W-1:0];
               freq_d = req.dat[FREQ_W-1:0];
            end
            `REG_BW: bw_d = req.dat[15:0];
            `REG_TIMEOUT: tmo_d = req.dat[23:0];
            `REG_SIGNAL: sig_lim_d = req.dat[7:0];
            `REG_CTRL: if (req.sel[0] && req.dat[`CTRL_CLEAR_FLAGS]) begin
               // A new preamble or temperature event in the same cycle wins over the clear; a new timeout does not
               pre_d = pre_evt;
               temp_d = temp_evt;
               tout_d = 1'b0;
            end
            default: ;
         endcase
      end else if (rd) begin
         ack_d = 1'b1;
         unique case (req.adr)
            `REG_CFG: rdat_d = cfg_q;
            `REG_CARRIER: rdat_d = 32'(freq_q);
            `REG_BW: rdat_d = {16'h0000, bw_q};
            `REG_TIMEOUT: rdat_d = {8'h00, tmo_q};
            `REG_SIGNAL: rdat_d = {16'h0000, s_sig2_q, sig_lim_q};
            `REG_STATUS: rdat_d = {26'h0, sigf_q, corr_phase_q, cal_q, tout_q, temp_q, pre_q};
            `REG_RESULT: rdat_d = 32'($signed(err_q));
            default: rdat_d = 32'h0000_0000;
         endcase
      end

      // Bandwidth select follows the next correction phase, so it leaves a flop
      abw_d = corr_phase_d ? bw_d[15:8] : bw_d[7:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // State registers; calibration starts at reset release
   always_ff @(posedge sys_clk) begin
      rx_q <= rx_on;
      tick_prev_q <= tick;
      mrst_q <= mrst;
      if (!nrst) begin
         cfg_q <= `CFG_RESET;
         base_q <= '0;
         freq_q <= '0;
         bw_q <= 16'h0000;
         abw_q <= 8'h00;
         tmo_q <= 24'h000000;
         sig_lim_q <= 8'hFF;
         rdat_q <= 32'h0000_0000;
         ack_q <= 1'b0;
         pre_q <= 1'b0;
         temp_q <= 1'b0;
         tout_q <= 1'b0;
         sigf_q <= 1'b0;
         err_q <= '0;
         acc_q <= '0;
         tref_q <= 8'h00;
         pcal_q <= 1'b1;
         cal_cnt_q <= 32'h0000_0000;
         cal_q <= 1'b0;
         cst_q <= CORR_IDLE;
         mcnt_q <= 3'h0;
         corr_phase_q <= 1'b0;
         run_q <= 5'h00;
         pcnt_q <= 6'h00;
         prev_bit_q <= 1'b0;
         tcnt_q <= '{default: 24'h0};
         tdone_q <= 3'h0;
      end else begin
         cfg_q <= cfg_d;
         base_q <= base_d;
         freq_q <= freq_d;
         bw_q <= bw_d;
         abw_q <= abw_d;
         tmo_q <= tmo_d;
         sig_lim_q <= sig_lim_d;
         rdat_q <= rdat_d;
         ack_q <= ack_d;
         pre_q <= pre_d;
         temp_q <= temp_d;
         tout_q <= tout_d;
         sigf_q <= sigf_d;
         err_q <= err_d;
         acc_q <= acc_d;
         tref_q <= pcal_q ? s_tmp2_q : tref_d;
         pcal_q <= pcal_d;
         cal_cnt_q <= pcal_q ? 32'(CAL_CYCLES) : cal_cnt_d;
         cal_q <= pcal_q | cal_d;
         cst_q <= cst_d;
         mcnt_q <= mcnt_d;
         corr_phase_q <= corr_phase_d;
         run_q <= run_d;
         pcnt_q <= pcnt_d;
         prev_bit_q <= prev_bit_d;
         tcnt_q <= tcnt_d;
         tdone_q <= tdone_d;
      end
   end

   // Outputs straight from flops
   assign wb_dat_o = rdat_q;
   assign wb_ack_o = ack_q;
   assign carrier_freq = freq_q;
   assign preamble_found_flag = pre_q;
   assign timeout_irq = tout_q;
   assign cal_busy = cal_q;
   // Registered bandwidth: correction bw during correction phase
   assign active_bandwidth = abw_q;

endmodule
`default_nettype wire

// ---- dv/rx_support_partner.sv ----
/*
 Radio front-end model: bit clock and demodulated bit stream.
 Assumes one bit period is eight system clocks; the tick runs free.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_support_partner (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic pre_on,
   output logic bit_tick,
   output logic rx_bit
);
   logic [4:0] cnt_q;
   logic [4:0] cnt_d;
   ////////////////////////////////////////
   // Free-running bit phase counter
   always_comb begin
      cnt_d = cnt_q + 5'h01;
   end
   always_ff @(posedge sys_clk) begin
      cnt_q <= nrst ? cnt_d : 5'h00;
   end
   // Tick rises mid-bit; bits change on its falling edge
   assign bit_tick = cnt_q[2];
   // Alternating bits in preamble, 0011 pattern otherwise
   assign rx_bit = pre_on ? cnt_q[3] : cnt_q[4];
endmodule
`default_nettype wire

// ---- dv/rx_support_monitor.sv ----
/*
 Port checker for rx_support.
 Assumes classic Wishbone and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rx_support_regs.svh"
module rx_support_monitor #(
   parameter int CAL_CYCLES = 50
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic manual_reset,
   input wire logic standby_mode,
   input wire logic preamble_found_flag,
   input wire logic timeout_irq,
   input wire logic cal_busy
);
   logic clr_d;
   logic clr_q;
   logic clr2_q;
   int cal_n_d;
   int cal_n_q;
   ////////////////////////////////////////
   // Recent flag-clear writes, calibration length
   always_comb begin
      clr_d = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == `REG_CTRL
              && wb_dat_i[`CTRL_CLEAR_FLAGS];
      cal_n_d = cal_busy ? cal_n_q + 1 : 0;
   end
   always_ff @(posedge sys_clk) begin
      clr_q <= nrst && clr_d;
      clr2_q <= nrst && clr_q;
      cal_n_q <= nrst ? cal_n_d : 0;
   end
   ////////////////////////////////////////
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   sequence take_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence launch_s;
      take_s ##0 (wb_we_i && wb_adr_i == `REG_CTRL && wb_dat_i[`CTRL_CAL_LAUNCH]
                  && standby_mode);
   endsequence
   sequence cal_go_s;
      ##[1:6] cal_busy;
   endsequence
   ack_timing_a: assert property (take_s |=> wb_ack_o) else $error("ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("stray ack");
   reset_clear_a: assert property (disable iff (1'b0)
      !nrst |=> !wb_ack_o && !timeout_irq && !preamble_found_flag) else $error("reset state");
   cal_power_a: assert property ($rose(nrst) |=> cal_busy) else $error("no cal");
   cal_manual_a: assert property ($rose(manual_reset) |-> cal_go_s)
      else $error("no manual cal");
   cal_launch_a: assert property (launch_s |-> cal_go_s) else $error("no launch");
   cal_length_a: assert property ($fell(cal_busy) |->
      cal_n_q >= CAL_CYCLES - 1 && cal_n_q <= CAL_CYCLES + 1) else $error("cal length");
   pre_hold_a: assert property ($fell(preamble_found_flag) |-> clr_q || clr2_q)
      else $error("flag lost");
   irq_hold_a: assert property ($fell(timeout_irq) |-> clr_q || clr2_q)
      else $error("irq lost");
endmodule
bind rx_support rx_support_monitor #(.CAL_CYCLES(CAL_CYCLES)) rx_support_monitor_inst (
   .sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .manual_reset(manual_reset), .standby_mode(standby_mode),
   .preamble_found_flag(preamble_found_flag), .timeout_irq(timeout_irq), .cal_busy(cal_busy));
`default_nettype wire

// ---- dv/rx_support_test.sv ----
/*
 Self-checking bench for rx_support with a front-end model.
 Assumes the register header and package are on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rx_support_regs.svh"
module rx_support_test;
   localparam int CAL = 50;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_sel_i = 4'hF;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic rx_enable = 1'b0;
   logic standby_mode = 1'b0;
   logic manual_reset = 1'b0;
   logic pre_on = 1'b0;
   logic sync_match_flag = 1'b0;
   logic bit_tick;
   logic rx_bit;
   logic [7:0] level = 8'h00;
   logic [7:0] temp = 8'h40;
   logic [15:0] err = 16'hFFFD;
   logic [23:0] carrier_freq;
   logic [7:0] active_bandwidth;
   logic preamble_found_flag;
   logic timeout_irq;
   logic cal_busy;
   logic [31:0] rd;
   int n_mismatch = 0;
   int total_checks = 0;
   int cyc_n = 0;
   always #2 sys_clk = ~sys_clk;
   rx_support #(.CAL_CYCLES(CAL)) rx_support_inst (.sys_clk(sys_clk), .nrst(nrst),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .rx_enable(rx_enable), .standby_mode(standby_mode), .manual_reset(manual_reset),
      .bit_tick(bit_tick), .rx_bit(rx_bit), .sync_match_flag(sync_match_flag),
      .signal_level_reading(level), .freq_error_sample(err), .temp_reading(temp),
      .carrier_freq(carrier_freq), .active_bandwidth(active_bandwidth),
      .preamble_found_flag(preamble_found_flag), .timeout_irq(timeout_irq),
      .cal_busy(cal_busy));
   rx_support_partner rx_support_partner_inst (.sys_clk(sys_clk), .nrst(nrst),
      .pre_on(pre_on), .bit_tick(bit_tick), .rx_bit(rx_bit));
   ////////////////////////////////////////
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic clk(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge bit_tick);
      clk(6);
   endtask
   // Classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      chk(32'(n < 20), 32'h1, "no ack");
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rx_restart;
      @(posedge sys_clk) rx_enable <= 1'b0;
      clk(6);
      rx_enable <= 1'b1;
   endtask
   ////////////////////////////////////////
   // Scenarios
   task automatic t_reset;
      clk(2);
      chk(cal_busy, 1, "power cal");
      wb(0, `REG_SIGNAL, 0);
      chk(rd[7:0], 8'hFF, "limit reset");
      wb(0, `REG_CFG, 0);
      chk(rd, `CFG_RESET, "cfg reset");
      wb(1, 8'h20, 32'h5A5A5A5A);
      wb(0, 8'h20, 0);
      chk(rd, 0, "unmapped");
      clk(CAL);
      chk(cal_busy, 0, "cal end");
      manual_reset <= 1'b1;
      clk(4);
      manual_reset <= 1'b0;
      clk(4);
      chk(cal_busy, 1, "manual cal");
      clk(CAL + 10);
      $display("reset test done");
   endtask
   task automatic t_corr;
      pre_on <= 1'b1;
      rx_enable <= 1'b1;
      clk(4);
      wb(1, `REG_CTRL, 32'h2);
      ticks(5);
      wb(0, `REG_RESULT, 0);
      chk(rd, 32'hFFFFFFFD, "result");
      wb(1, `REG_CARRIER, 32'h100000);
      wb(1, `REG_BW, 32'h2211);
      wb(1, `REG_CFG, 32'h3);
      rx_restart;
      clk(8);
      chk(active_bandwidth, 8'h22, "corr bw");
      ticks(8);
      chk(carrier_freq, 24'h100003, "corrected");
      chk(active_bandwidth, 8'h11, "chan bw");
      rx_restart;
      ticks(8);
      chk(carrier_freq, 24'h100003, "from centre");
      wb(1, `REG_CFG, 32'h1);
      rx_restart;
      ticks(8);
      chk(carrier_freq, 24'h100006, "from last");
      wb(1, `REG_CARRIER, 32'h200000);
      wb(1, `REG_CFG, 32'h000A_004F);
      pre_on <= 1'b0;
      rx_restart;
      ticks(12);
      chk(carrier_freq, 24'h200000, "gate wait");
      pre_on <= 1'b1;
      ticks(24);
      chk(carrier_freq, 24'h200003, "gated corr");
      $display("correction test done");
   endtask
   task automatic t_pre;
      logic [7:0] cf[5] = '{8'h04, 8'h44, 8'h84, 8'hC4, 8'h00};
      int lo[5] = '{5, 12, 20, 12, 5};
      int hi[5] = '{14, 22, 30, 22, 30};
      for (int i = 0; i < 5; i++) begin
         pre_on <= 1'b0;
         wb(1, `REG_CFG, 32'(cf[i]));
         ticks(4);
         wb(1, `REG_CTRL, 32'h4);
         pre_on <= 1'b1;
         ticks(lo[i]);
         chk(preamble_found_flag, 0, "early flag");
         ticks(hi[i] - lo[i]);
         chk(preamble_found_flag, 32'(cf[i] != 0), "flag");
      end
      $display("preamble test done");
   endtask
   task automatic t_tmo;
      logic [2:0] tr[6] = '{3'h6, 3'h0, 3'h1, 3'h1, 3'h7, 3'h1};
      logic [31:0] to[6] = '{32'h100, 32'h100, 32'h1, 32'h1, 32'h100, 32'h10000};
      logic [7:0] lv[6] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00};
      logic ex[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
      for (int i = 0; i < 6; i++) begin
         @(posedge sys_clk);
         rx_enable <= 1'b0;
         pre_on <= 1'b0;
         level <= lv[i];
         wb(1, `REG_CFG, 32'(tr[i]) << `CFG_TRIG_LO);
         wb(1, `REG_TIMEOUT, to[i]);
         wb(1, `REG_SIGNAL, 32'h10);
         wb(1, `REG_CTRL, 32'h4);
         rx_enable <= 1'b1;
         ticks(12);
         chk(timeout_irq, 0, "early timeout");
         ticks(8);
         chk(timeout_irq, 32'(ex[i]), "timeout");
      end
      $display("timeout test done");
   endtask
   task automatic t_cal;
      standby_mode <= 1'b1;
      clk(4);
      wb(1, `REG_CTRL, 32'h1);
      clk(4);
      chk(cal_busy, 1, "launch");
      clk(CAL + 10);
      chk(cal_busy, 0, "launch end");
      wb(1, `REG_CFG, 32'h20);
      temp <= temp + 8'h0A;
      clk(10);
      chk(cal_busy, 1, "temp cal");
      wb(0, `REG_STATUS, 0);
      chk(rd[1], 1, "temp flag");
      clk(CAL + 10);
      wb(1, `REG_CFG, 32'h10);
      wb(1, `REG_CTRL, 32'h4);
      temp <= temp + 8'h0A;
      clk(10);
      wb(0, `REG_STATUS, 0);
      chk(rd[1], 0, "watch off");
      wb(1, `REG_CFG, 32'h300);
      clk(10);
      wb(0, `REG_STATUS, 0);
      chk(rd[1], 0, "step hold");
      temp <= temp + 8'h0A;
      clk(10);
      wb(0, `REG_STATUS, 0);
      chk({rd[1], cal_busy}, 2'b10, "flag only");
      $display("calibration test done");
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////
   // Main sequence and hang guard
   initial begin
      clk(6);
      nrst <= 1'b1;
      t_reset;
      t_corr;
      t_pre;
      t_tmo;
      t_cal;
      print_verdict;
   end
   always @(posedge sys_clk) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         n_mismatch++;
         print_verdict;
      end
   end
endmodule
`default_nettype wire
